// >>> scan_cycle_time_monitor_tb_top.sv
// self-checking testbench for the scan cycle time monitor
`timescale 1ns/1ps
module scan_cycle_time_monitor_tb_top;
	localparam int CPT = 10; // clock cycles per simulated millisecond
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic startup_done = 1'b0, pass_end = 1'b0, retrig = 1'b0;
	logic in_handler = 1'b0, handler_done = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, run, stop, pass_start, fill, req, irq;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rd;
	logic [7:0] cause;
	logic [12:0] budget;
	logic s_stop, s_req;
	int fails = 0;
	int check_count = 0;
	int c;
	longint t0;
	// clamp cases: address, written value, value read back
	logic [7:0] cl_a [0:6] = '{scm_pkg::OFF_MAX_MS, scm_pkg::OFF_MAX_MS, scm_pkg::OFF_MIN_MS,
		scm_pkg::OFF_MIN_MS, scm_pkg::OFF_COMM_PCT, scm_pkg::OFF_MAX_MS, scm_pkg::OFF_COMM_PCT};
	logic [31:0] cl_w [0:6] = '{32'h0000_0000, 32'h0000_1B58, 32'h0000_1B58, 32'h0000_0000,
		32'h0000_00C8, 32'h0000_00C8, 32'h0000_0032};
	logic [31:0] cl_r [0:6] = '{32'h0000_0001, 32'h0000_1770, 32'h0000_1770, 32'h0000_0001,
		32'h0000_0064, 32'h0000_00C8, 32'h0000_0032};

	// 200 mhz clock
	always #2.5 sys_clk_i = ~sys_clk_i;

	// device under test with a short millisecond
	scm_monitor #(.CYC_PER_TICK(CPT)) scm_monitor_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .startup_done_i(startup_done),
		.pass_end_i(pass_end), .cycle_timer_retrigger_i(retrig), .in_handler_i(in_handler),
		.handler_done_i(handler_done), .run_o(run), .stop_o(stop), .pass_start_o(pass_start),
		.fill_active_o(fill), .time_error_handler_req_o(req), .time_error_cause_o(cause),
		.comm_budget_ms_o(budget), .irq_o(irq));

	// prints the verdict and ends the run
	task automatic print_verdict();
		if (fails == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict

	// compares one value
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// a wait that ran out counts as a mismatch and ends the run
	task automatic give_up(input string name);
		fails++;
		$display("mismatch %s expected answer seen timeout", name);
		print_verdict();
	endtask : give_up

	// axi4-lite write, address and data offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk_i);
			n++;
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 200);
		if (n >= 200) give_up("write response");
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	// axi4-lite read
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk_i);
			n++;
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 200);
		if (n >= 200) give_up("read data");
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	// write expecting an okay response
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_wr(a, d, rsp);
		chk("bresp", 32'(scm_pkg::RESP_OKAY), 32'(rsp));
	endtask : wr

	// read and compare with an okay response
	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		axi_rd(a, rd, rsp);
		chk(name, exp, rd);
		chk("rresp", 32'(scm_pkg::RESP_OKAY), 32'(rsp));
	endtask : rdchk

	// selects an observed output
	function automatic logic sig(input int sel);
		case (sel)
			0: return pass_start;
			1: return fill;
			2: return req;
			3: return stop;
			default: return irq;
		endcase
	endfunction : sig

	// bounded wait for an output, sampled just after each edge
	task automatic wait_sig(input int sel, input int bound, output int n);
		n = 0;
		while (sig(sel) !== 1'b1 && n < bound) begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
		if (sig(sel) !== 1'b1) give_up("output wait");
	endtask : wait_sig

	// one-cycle end of pass, returns just after the edge that takes it
	task automatic pulse_end();
		@(posedge sys_clk_i);
		pass_end <= 1'b1;
		@(posedge sys_clk_i);
		pass_end <= 1'b0;
		#1;
	endtask : pulse_end

	// retriggers every per cycles for cyc cycles, noting stop and dispatch
	task automatic retrig_run(input logic inh, input int per, input int cyc);
		s_stop = 1'b0;
		s_req = 1'b0;
		for (int i = 0; i < cyc; i++) begin
			@(posedge sys_clk_i);
			in_handler <= inh;
			retrig <= (i % per == 0);
			#1;
			if (stop === 1'b1) s_stop = 1'b1;
			if (req === 1'b1) s_req = 1'b1;
		end
		@(posedge sys_clk_i);
		retrig <= 1'b0;
		in_handler <= 1'b0;
	endtask : retrig_run

	// synchronous reset for two cycles
	task automatic do_reset();
		@(posedge sys_clk_i);
		rst_n_i <= 1'b0;
		startup_done <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
	endtask : do_reset

	// end of startup, then the first pass begins
	task automatic start_up();
		@(posedge sys_clk_i);
		startup_done <= 1'b1;
		wait_sig(0, 5, c);
	endtask : start_up

	// main sequence
	initial begin
		do_reset();
		rdchk("ctrl", scm_pkg::OFF_CTRL, 32'h0000_0000);
		rdchk("max", scm_pkg::OFF_MAX_MS, 32'h0000_0096);
		rdchk("pct", scm_pkg::OFF_COMM_PCT, 32'h0000_0014);
		rdchk("mask", scm_pkg::OFF_IRQ_MASK, 32'h0000_0000);
		// timer runs free in startup: one millisecond has passed when status is taken
		rdchk("status", scm_pkg::OFF_STATUS, 32'h0000_4001);
		chk("state", 32'h0000_0001, (rd >> 14) & 32'h0000_000F);
		chk("run", 32'h0000_0000, 32'(run));
		axi_rd(8'h1C, rd, rsp);
		chk("unmapped rresp", 32'(scm_pkg::RESP_SLVERR), 32'(rsp));
		chk("unmapped rdata", 32'h0000_0000, rd);
		axi_wr(8'h02, 32'h0000_0005, rsp);
		chk("unaligned bresp", 32'(scm_pkg::RESP_SLVERR), 32'(rsp));
		for (int i = 0; i < 7; i++) begin
			wr(cl_a[i], cl_w[i]);
			rdchk("clamp", cl_a[i], cl_r[i]);
		end
		chk("comm budget", 32'h0000_0064, 32'(budget));
		start_up();
		chk("run", 32'h0000_0001, 32'(run));
		pulse_end();
		chk("next pass", 32'h0000_0001, 32'(pass_start));
		wr(scm_pkg::OFF_MIN_MS, 32'h0000_0003);
		wr(scm_pkg::OFF_CTRL, 32'h0000_0004);
		wr(scm_pkg::OFF_IRQ_MASK, 32'h0000_0003);
		pulse_end();
		wait_sig(0, 80, c);
		t0 = $time;
		pulse_end();
		chk("early pass start", 32'h0000_0000, 32'(pass_start));
		wait_sig(1, 3, c);
		wait_sig(0, 80, c);
		c = int'(($time - t0) / 5);
		chk("padded pass", 32'h0000_0001, 32'(c >= 2 * CPT && c <= 4 * CPT));
		repeat (5 * CPT) @(posedge sys_clk_i);
		pulse_end();
		chk("late pass start", 32'h0000_0001, 32'(pass_start));
		chk("late fill", 32'h0000_0000, 32'(fill));
		rdchk("late status", scm_pkg::OFF_IRQ_STS, 32'h0000_0000);
		wr(scm_pkg::OFF_CTRL, 32'h0000_0001);
		wr(scm_pkg::OFF_MAX_MS, 32'h0000_0002);
		wait_sig(4, 100, c);
		chk("ignore run", 32'h0000_0001, 32'(run));
		chk("ignore stop", 32'h0000_0000, 32'(stop));
		wr(scm_pkg::OFF_MAX_MS, 32'h0000_0096);
		wr(scm_pkg::OFF_IRQ_STS, 32'h0000_0001);
		rdchk("cleared", scm_pkg::OFF_IRQ_STS, 32'h0000_0000);
		chk("irq low", 32'h0000_0000, 32'(irq));
		wr(scm_pkg::OFF_CTRL, 32'h0000_0002);
		pulse_end();
		wr(scm_pkg::OFF_MAX_MS, 32'h0000_0002);
		wait_sig(2, 100, c);
		chk("cause", 32'h0000_0001, 32'(cause));
		chk("handler stop", 32'h0000_0000, 32'(stop));
		retrig_run(1'b1, 5, 120);
		chk("retrigger in handler", 32'h0000_0001, 32'(s_stop));
		chk("stopped run", 32'h0000_0000, 32'(run));
		rdchk("stop status", scm_pkg::OFF_IRQ_STS, 32'h0000_0003);
		// accepted retriggers keep the pass alive
		do_reset();
		wr(scm_pkg::OFF_MAX_MS, 32'h0000_0002);
		wr(scm_pkg::OFF_CTRL, 32'h0000_0002);
		wr(scm_pkg::OFF_IRQ_MASK, 32'h0000_0003);
		repeat (6 * CPT) @(posedge sys_clk_i);
		chk("startup irq", 32'h0000_0000, 32'(irq));
		start_up();
		retrig_run(1'b0, 5, 150);
		chk("retrigger dispatch", 32'h0000_0000, 32'(s_req));
		chk("retrigger stop", 32'h0000_0000, 32'(s_stop));
		wait_sig(2, 100, c);
		@(posedge sys_clk_i);
		handler_done <= 1'b1;
		@(posedge sys_clk_i);
		handler_done <= 1'b0;
		retrig_run(1'b0, 1000, 60);
		chk("second dispatch", 32'h0000_0001, 32'(s_req));
		chk("no stop", 32'h0000_0000, 32'(s_stop));
		// default reaction without handler
		do_reset();
		wr(scm_pkg::OFF_MAX_MS, 32'h0000_0002);
		wr(scm_pkg::OFF_IRQ_MASK, 32'h0000_0003);
		start_up();
		wait_sig(3, 100, c);
		chk("stop run", 32'h0000_0000, 32'(run));
		chk("stop irq", 32'h0000_0001, 32'(irq));
		rdchk("stop sts", scm_pkg::OFF_IRQ_STS, 32'h0000_0003);
		pulse_end();
		chk("no pass in stop", 32'h0000_0000, 32'(pass_start));
		print_verdict();
	end
endmodule : scan_cycle_time_monitor_tb_top

// >>> scm_monitor.sv
// scan cycle time supervisor with axi4-lite configuration port
`timescale 1ns/1ps
module scm_monitor #(
	parameter int CYC_PER_TICK = scm_pkg::CYC_PER_TICK
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic startup_done_i,
	input wire logic pass_end_i,
	input wire logic cycle_timer_retrigger_i,
	input wire logic in_handler_i,
	input wire logic handler_done_i,
	output logic run_o,
	output logic stop_o,
	output logic pass_start_o,
	output logic fill_active_o,
	output logic time_error_handler_req_o,
	output logic [7:0] time_error_cause_o,
	output logic [12:0] comm_budget_ms_o,
	output logic irq_o
);
	scm_tmr_if tmr ();
	scm_pkg::scm_state_t state_reg, state_next;
	logic [2:0] ctrl_reg;
	logic [12:0] max_ms_reg, min_ms_reg, eff_min;
	logic [6:0] pct_reg;
	logic [1:0] irq_sts_reg, irq_mask_reg, irq_set;
	logic exceeded_once_reg, handler_active_reg;
	logic exceed_c, retrig_ok, start_pass, first_over, clear_c;
	logic aw_got_reg, w_got_reg, do_write;
	logic [7:0] aw_addr_reg;
	logic [31:0] wdata_reg;

	// keep a setting inside [lo, hi]
	function automatic logic [12:0] clamp_ms(input logic [12:0] v, input logic [12:0] lo,
			input logic [12:0] hi);
		clamp_ms = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp_ms

	scm_ms_timer #(.CYC_PER_TICK(CYC_PER_TICK)) u_timer (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.tmr(tmr)
	);

	// supervision decisions
	assign eff_min = clamp_ms(min_ms_reg, scm_pkg::MS_LO, max_ms_reg);
	assign exceed_c = (state_reg == scm_pkg::ST_SCAN) && tmr.tick
		&& (tmr.elapsed_ms >= max_ms_reg);
	assign retrig_ok = cycle_timer_retrigger_i && !in_handler_i && !handler_active_reg
		&& (state_reg == scm_pkg::ST_SCAN);
	assign first_over = exceed_c && !exceeded_once_reg;
	assign start_pass = (state_next == scm_pkg::ST_SCAN) && (state_reg != scm_pkg::ST_SCAN
		|| (pass_end_i && !exceed_c));
	assign clear_c = start_pass || retrig_ok || first_over;
	assign tmr.clear = clear_c;

	// next state of the supervisor
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			scm_pkg::ST_STARTUP: begin
				if (startup_done_i) begin
					state_next = scm_pkg::ST_SCAN;
				end
			end
			scm_pkg::ST_SCAN: begin
				if (exceed_c && exceeded_once_reg) begin
					state_next = scm_pkg::ST_STOP;
				end else if (exceed_c && !ctrl_reg[scm_pkg::CTRL_HANDLER_BIT]
						&& !ctrl_reg[scm_pkg::CTRL_IGNORE_BIT]) begin
					state_next = scm_pkg::ST_STOP;
				end else if (pass_end_i && !exceed_c && ctrl_reg[scm_pkg::CTRL_MIN_EN_BIT]
						&& tmr.elapsed_ms < eff_min) begin
					state_next = scm_pkg::ST_FILL;
				end
			end
			scm_pkg::ST_FILL: begin
				if (tmr.elapsed_ms >= eff_min) begin
					state_next = scm_pkg::ST_SCAN;
				end
			end
			scm_pkg::ST_STOP: state_next = scm_pkg::ST_STOP;
		endcase
	end

	// state and its registered views
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_reg <= scm_pkg::ST_STARTUP;
			run_o <= 1'b0;
			stop_o <= 1'b0;
			fill_active_o <= 1'b0;
			pass_start_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			run_o <= (state_next == scm_pkg::ST_SCAN) || (state_next == scm_pkg::ST_FILL);
			stop_o <= (state_next == scm_pkg::ST_STOP);
			fill_active_o <= (state_next == scm_pkg::ST_FILL);
			pass_start_o <= start_pass;
		end
	end

	// overrun memory within a pass and handler dispatch
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			exceeded_once_reg <= 1'b0;
			handler_active_reg <= 1'b0;
			time_error_handler_req_o <= 1'b0;
			time_error_cause_o <= 8'h00;
		end else begin
			time_error_handler_req_o <= 1'b0;
			if (first_over) begin
				exceeded_once_reg <= 1'b1;
			end else if (start_pass || retrig_ok) begin
				exceeded_once_reg <= 1'b0;
			end
			if (first_over && ctrl_reg[scm_pkg::CTRL_HANDLER_BIT]) begin
				handler_active_reg <= 1'b1;
				time_error_handler_req_o <= 1'b1;
				time_error_cause_o <= scm_pkg::CAUSE_MAX_CYCLE;
			end else if (handler_done_i) begin
				handler_active_reg <= 1'b0;
			end
		end
	end

	// communication share of the maximum cycle time
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			comm_budget_ms_o <= 13'h0000;
		end else begin
			comm_budget_ms_o <= 13'((20'(max_ms_reg) * 20'(pct_reg)) / 20'd100);
		end
	end

	// sticky interrupt status, write-one-to-clear only with data bit 31 low, set wins over the clear
	assign irq_set = {(state_next == scm_pkg::ST_STOP) && (state_reg != scm_pkg::ST_STOP),
		exceed_c};
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			irq_sts_reg <= 2'h0;
			irq_o <= 1'b0;
		end else begin
			if (do_write && aw_addr_reg == scm_pkg::OFF_IRQ_STS && wdata_reg[31] == 1'b0) begin
				irq_sts_reg <= (irq_sts_reg & ~wdata_reg[1:0]) | irq_set;
			end else begin
				irq_sts_reg <= irq_sts_reg | irq_set;
			end
			irq_o <= |((irq_sts_reg | irq_set) & irq_mask_reg);
		end
	end

	// axi4-lite write address and data capture, either order
	assign do_write = aw_got_reg && w_got_reg && !s_axi_bvalid_o;
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o <= 1'b0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= scm_pkg::RESP_OKAY;
		end else begin
			s_axi_awready_o <= !aw_got_reg && !(s_axi_awvalid_i && s_axi_awready_o);
			s_axi_wready_o <= !w_got_reg && !(s_axi_wvalid_i && s_axi_wready_o);
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_got_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_got_reg <= 1'b1;
				wdata_reg <= s_axi_wdata_i & {{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}},
					{8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};
			end
			if (do_write) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= (aw_addr_reg > scm_pkg::OFF_IRQ_MASK || aw_addr_reg[1:0] != 2'h0)
					? scm_pkg::RESP_SLVERR : scm_pkg::RESP_OKAY;
			end else if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end

	// configuration registers, settings clamped into their legal ranges
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			ctrl_reg <= scm_pkg::CTRL_RST;
			max_ms_reg <= scm_pkg::MAX_MS_RST;
			min_ms_reg <= scm_pkg::MIN_MS_RST;
			pct_reg <= scm_pkg::PCT_RST;
			irq_mask_reg <= 2'h0;
		end else if (do_write) begin
			unique case (aw_addr_reg)
				scm_pkg::OFF_CTRL: ctrl_reg <= wdata_reg[2:0];
				scm_pkg::OFF_MAX_MS: max_ms_reg <= clamp_ms(wdata_reg[31:13] != 19'h0_0000
					? 13'h1FFF : wdata_reg[12:0], scm_pkg::MS_LO, scm_pkg::MAX_MS_HI);
				scm_pkg::OFF_MIN_MS: min_ms_reg <= clamp_ms(wdata_reg[31:13] != 19'h0_0000
					? 13'h1FFF : wdata_reg[12:0], scm_pkg::MS_LO, max_ms_reg);
				scm_pkg::OFF_COMM_PCT: pct_reg <= (wdata_reg[31:0] > 32'(scm_pkg::PCT_HI))
					? scm_pkg::PCT_HI : wdata_reg[6:0];
				scm_pkg::OFF_IRQ_MASK: irq_mask_reg <= wdata_reg[1:0];
				default: ;
			endcase
		end
	end

	// axi4-lite read channel
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= scm_pkg::RESP_OKAY;
		end else begin
			s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
			if (s_axi_arvalid_i && s_axi_arready_o) begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rresp_o <= scm_pkg::RESP_OKAY;
				unique case (s_axi_araddr_i)
					scm_pkg::OFF_CTRL: s_axi_rdata_o <= {29'h0000_0000, ctrl_reg};
					scm_pkg::OFF_MAX_MS: s_axi_rdata_o <= {19'h0_0000, max_ms_reg};
					scm_pkg::OFF_MIN_MS: s_axi_rdata_o <= {19'h0_0000, min_ms_reg};
					scm_pkg::OFF_COMM_PCT: s_axi_rdata_o <= {25'h000_0000, pct_reg};
					scm_pkg::OFF_STATUS: s_axi_rdata_o <= {12'h000, handler_active_reg,
						exceeded_once_reg, state_reg, 1'b0, tmr.elapsed_ms};
					scm_pkg::OFF_IRQ_STS: s_axi_rdata_o <= {30'h0000_0000, irq_sts_reg};
					scm_pkg::OFF_IRQ_MASK: s_axi_rdata_o <= {30'h0000_0000, irq_mask_reg};
					default: begin
						s_axi_rdata_o <= 32'h0000_0000;
						s_axi_rresp_o <= scm_pkg::RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
	end

	// checks on the supervisor
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence fill_done_s;
		(state_reg == scm_pkg::ST_FILL) && (tmr.elapsed_ms >= eff_min);
	endsequence
	sequence next_pass_s;
		pass_start_o && run_o && !fill_active_o;
	endsequence

	startup_hold_a: assert property ((state_reg == scm_pkg::ST_STARTUP && !startup_done_i)
		|=> !run_o && !irq_sts_reg[scm_pkg::IRQ_OVERRUN_BIT])
		else $error("supervision active before startup completed");
	overrun_flag_a: assert property (exceed_c |=> irq_sts_reg[scm_pkg::IRQ_OVERRUN_BIT])
		else $error("overrun not flagged");
	stop_default_a: assert property (first_over && ctrl_reg == 3'h0 |=> ##1 stop_o && !run_o)
		else $error("overrun without handler did not stop");
	handler_call_a: assert property (first_over && ctrl_reg[scm_pkg::CTRL_HANDLER_BIT]
		|=> time_error_handler_req_o && time_error_cause_o == scm_pkg::CAUSE_MAX_CYCLE
		##1 !time_error_handler_req_o && !stop_o)
		else $error("handler not dispatched with cause one");
	retrig_clear_a: assert property (retrig_ok && !first_over |=> tmr.elapsed_ms == 13'h0000
		&& !exceeded_once_reg)
		else $error("accepted retrigger did not restart timer");
	retrig_ignore_a: assert property (cycle_timer_retrigger_i && in_handler_i
		&& state_reg == scm_pkg::ST_SCAN && !pass_end_i && !exceed_c
		&& tmr.elapsed_ms != 13'h0000 |=> tmr.elapsed_ms != 13'h0000)
		else $error("retrigger inside handler accepted");
	double_stop_a: assert property (exceed_c && exceeded_once_reg |=> ##1 stop_o)
		else $error("second overrun did not stop");
	no_min_next_a: assert property (state_reg == scm_pkg::ST_SCAN && pass_end_i && !exceed_c
		&& !ctrl_reg[scm_pkg::CTRL_MIN_EN_BIT] |=> next_pass_s)
		else $error("next pass not started at once");
	fill_end_a: assert property (fill_done_s |=> next_pass_s)
		else $error("fill did not end at minimum");
	min_over_a: assert property (state_reg == scm_pkg::ST_SCAN && pass_end_i && !exceed_c
		&& tmr.elapsed_ms >= eff_min |=> !$rose(time_error_handler_req_o)
		&& state_reg == scm_pkg::ST_SCAN)
		else $error("minimum overrun caused a reaction");
	max_range_a: assert property (max_ms_reg >= scm_pkg::MS_LO
		&& max_ms_reg <= scm_pkg::MAX_MS_HI)
		else $error("maximum out of range");
	// the budget register lags a new maximum by one cycle
	comm_range_a: assert property (pct_reg <= scm_pkg::PCT_HI
		&& comm_budget_ms_o <= $past(max_ms_reg))
		else $error("communication share out of range");
endmodule : scm_monitor

// >>> scm_ms_timer.sv
// millisecond cycle timer with prescaler
`timescale 1ns/1ps
module scm_ms_timer #(
	parameter int CYC_PER_TICK = scm_pkg::CYC_PER_TICK
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	scm_tmr_if.tmr tmr
);
	localparam int PW = $clog2(CYC_PER_TICK + 1);
	localparam logic [PW-1:0] LAST = PW'(CYC_PER_TICK - 1);
	logic [PW-1:0] presc_reg;
	logic [12:0] elapsed_reg;

	// tick fires at the last prescaler count; clear is built from tick, so gating would loop
	assign tmr.tick = (presc_reg == LAST);
	assign tmr.elapsed_ms = elapsed_reg;

	// prescaler restarts with the count so each pass is timed from a clean edge
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || tmr.clear || presc_reg == LAST) begin
			presc_reg <= '0;
		end else begin
			presc_reg <= presc_reg + PW'(1);
		end
	end

	// elapsed milliseconds, saturating
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || tmr.clear) begin
			elapsed_reg <= 13'h0000;
		end else if (tmr.tick && elapsed_reg != 13'h1FFF) begin
			elapsed_reg <= elapsed_reg + 13'h0001;
		end
	end
endmodule : scm_ms_timer

// >>> scm_pkg.sv
// constants and types shared by the scan cycle time monitor
package scm_pkg;
	// register byte offsets on the axi4-lite port
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_MAX_MS = 8'h04;
	localparam logic [7:0] OFF_MIN_MS = 8'h08;
	localparam logic [7:0] OFF_COMM_PCT = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_IRQ_STS = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
	localparam int ADDR_W = 8;
	// control register fields
	localparam int CTRL_W = 3;
	localparam int CTRL_IGNORE_BIT = 0;
	localparam int CTRL_HANDLER_BIT = 1;
	localparam int CTRL_MIN_EN_BIT = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;
	// millisecond and percentage settings
	localparam int MS_W = 13;
	localparam logic [12:0] MS_LO = 13'h0001;
	localparam logic [12:0] MAX_MS_HI = 13'h1770;
	localparam logic [12:0] MAX_MS_RST = 13'h0096;
	localparam logic [12:0] MIN_MS_RST = 13'h0001;
	localparam int PCT_W = 7;
	localparam logic [6:0] PCT_HI = 7'h64;
	localparam logic [6:0] PCT_RST = 7'h14;
	// handler cause code for a maximum cycle overrun
	localparam logic [7:0] CAUSE_MAX_CYCLE = 8'h01;
	// interrupt status fields
	localparam int IRQ_W = 2;
	localparam int IRQ_OVERRUN_BIT = 0;
	localparam int IRQ_STOP_BIT = 1;
	// timing: one tick is one millisecond
	localparam int TICK_NS = 1000000;
	localparam int CLK_NS = 5;
	localparam int CYC_PER_TICK = TICK_NS / CLK_NS;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// supervisor states
	typedef enum logic [3:0] {
		ST_STARTUP = 4'h1,
		ST_SCAN = 4'h2,
		ST_FILL = 4'h4,
		ST_STOP = 4'h8
	} scm_state_t;
endpackage : scm_pkg

// >>> scm_tmr_if.sv
// link between the supervisor and its millisecond timer
`timescale 1ns/1ps
interface scm_tmr_if;
	logic clear;
	logic tick;
	logic [12:0] elapsed_ms;
	modport ctl (output clear, input tick, input elapsed_ms);
	modport tmr (input clear, output tick, output elapsed_ms);
endinterface : scm_tmr_if
